// ===== clc_capacity_learning_counter.v
// How it works
// [RL1] temperature is a nested cubic of the raw code, floor gives clamp value
// [RL2] remaining charge rises to learned capacity, falls to zero
// [RL3] remaining charge kept in mAh or 10 mWh per unit select
// [RL4] remaining charge recalibrated to recalValue on the recalValid strobe; the midrange strobe does not change it
// [RL5] learned capacity loaded from stored capacity at init
// [RL6] new learned capacity written back in mAh, flagged late if still unacknowledged after 4 s
// [RL7] tally counts discharge, load and self-discharge, not readable
// [RL8] tally preset to learned minus remaining at near-full discharge start
// [RL9] preset reduced by learned/128 when offset select bit set
// [RL10] tally stops at the second low-voltage level
// [RL11] new capacity is tally plus learned times low-battery fraction
// [RL12] low-battery fraction is stored byte divided by 2.56
// [RL13] qualified only from near full down to level two
// [RL14] 10 mAh of charge during discharge disqualifies
// [RL15] over 256 mAh of estimates disqualifies
// [RL16] temperature below learning floor at level two disqualifies
// [RL17] voltage below level two minus 384 mV disqualifies
// [RL18] midrange correction during discharge disqualifies
// [RL19] current below 3C/32 at level two or low battery disqualifies
// [RL20] overload at level two or low battery disqualifies
// [RL21] qualified flag set at qualified start, cleared on disqualify
// [RL22] one update drops at most 256 mAh, rises at most 512 mAh
// [RL23] update only if still qualified at level two
`include "clc_capacity_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module clc_capacity_learning_counter #(
  parameter [31:0] WRITEBACK_LIMIT = `CLC_WRITEBACK_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // charge flow, one pulse per measured quantum
  input  wire        chargeValid,
  input  wire [15:0] chargeMah,
  input  wire        dischargeValid,
  input  wire [15:0] dischargeMah,
  input  wire        selfDischargeValid,
  input  wire [15:0] selfDischargeMah,
  input  wire        loadEstValid,
  input  wire [15:0] loadEstMah,
  // measurements
  input  wire [15:0] packVoltageMv,
  input  wire [15:0] currentMa,
  input  wire        overload,
  input  wire        tempRawValid,
  input  wire [15:0] tempRaw,
  // threshold events
  input  wire        levelTwoDetect,
  input  wire [15:0] levelTwoThresholdMv,
  input  wire        recalValid,
  input  wire [15:0] recalValue,
  input  wire        midrangeCorrect,
  // nonvolatile store
  input  wire [15:0] nvStoredCapacity,
  output reg         nvWriteReq,
  output reg  [15:0] nvWriteData,
  input  wire        nvWriteAck,
  // loose outputs
  output wire        internalSensorSelect,
  output wire        dischargeQualified
);

  localparam [1:0] T_IDLE = 2'b00;
  localparam [1:0] T_STEP = 2'b01;

  // saturating helpers, used by several counters
  function [15:0] satAdd;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      satAdd = s[16] ? 16'hFFFF : s[15:0];
    end
  endfunction

  function [15:0] satSub;
    input [15:0] a;
    input [15:0] b;
    begin
      satSub = (a > b) ? a - b : 16'h0000;
    end
  endfunction

  // mAh to 10 mWh at the present pack voltage
  function [15:0] toUnits;
    input [15:0] q;
    input [15:0] mv;
    input        energy;
    reg   [31:0] p;
    begin
      p = q * mv;
      p = p / `CLC_MWH_DIVISOR;
      if (!energy)
        toUnits = q;
      else if (p[31:16] != 16'h0000)
        toUnits = 16'hFFFF;
      else
        toUnits = p[15:0];
    end
  endfunction

  // software-visible settings
  reg  [7:0]  gaugeCfg_q, miscCfg_q, lowBatt_q, ctrl_q;
  reg  [15:0] nearFull_q, designCap_q, learnLowT_q;
  reg  [15:0] coefCubic_q, coefSquare_q, coefLinear_q, coefOffset_q;
  reg  [15:0] tempFloor_q, tempClamp_q;
  // gauge state
  reg  [15:0] rm_q, fcc_q, tally_q, chgAcc_q, estAcc_q, temp_q;
  reg         qual_q, disch_q, run_q, lowSeen_q, initLoad_q, nvLate_q;
  reg  [31:0] nvAge_q;
  // bus state
  reg  [7:0]  idx_q;
  reg         wrPend_q, mapped_q, rdPhase_q;
  // temperature engine
  reg  [1:0]  tState_q, tStep_q;
  reg  [15:0] ad_q;
  reg  signed [31:0] tAcc_q;

  wire        unitEnergy = ctrl_q[`CLC_CTRL_UNIT_ENERGY];
  wire [15:0] capUnits   = toUnits(fcc_q, packVoltageMv, unitEnergy);

  assign internalSensorSelect = miscCfg_q[`CLC_MISC_INT_SENSOR];
  assign dischargeQualified   = qual_q;
  assign hresp                = 1'b0;
  // reads pay one wait state so the mux sees writes just retired
  assign hreadyout            = ~rdPhase_q;

  // ------------------------------------------------------------------
  // bus slave
  wire       busTake  = hsel & hready & htrans[1];
  wire [7:0] busIdx   = haddr[9:2];
  wire       busInMap = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'b00);

  // decode of implemented indices
  function isMapped;
    input [7:0] i;
    begin
      case (i)
        `CLC_IDX_GAUGE_CFG, `CLC_IDX_MISC_CFG, `CLC_IDX_LOW_BATT,
        `CLC_IDX_NEAR_FULL, `CLC_IDX_DESIGN_CAP, `CLC_IDX_STORED_CAP,
        `CLC_IDX_LEARN_LOW_T, `CLC_IDX_COEF_CUBIC, `CLC_IDX_COEF_SQUARE,
        `CLC_IDX_COEF_LINEAR, `CLC_IDX_COEF_OFFSET, `CLC_IDX_TEMP_FLOOR,
        `CLC_IDX_TEMP_CLAMP, `CLC_IDX_CTRL, `CLC_IDX_STATUS,
        `CLC_IDX_REMAINING, `CLC_IDX_LEARNED,
        `CLC_IDX_TEMPERATURE: isMapped = 1'b1;
        default:              isMapped = 1'b0;
      endcase
    end
  endfunction

  // read mux, unmapped reads return zero; the tally has no index
  reg [15:0] rdMux;
  always @* begin
    case (idx_q)
      `CLC_IDX_GAUGE_CFG:    rdMux = {8'h00, gaugeCfg_q};
      `CLC_IDX_MISC_CFG:     rdMux = {8'h00, miscCfg_q};
      `CLC_IDX_LOW_BATT:     rdMux = {8'h00, lowBatt_q};
      `CLC_IDX_NEAR_FULL:    rdMux = nearFull_q;
      `CLC_IDX_DESIGN_CAP:   rdMux = designCap_q;
      `CLC_IDX_STORED_CAP:   rdMux = nvStoredCapacity;
      `CLC_IDX_LEARN_LOW_T:  rdMux = learnLowT_q;
      `CLC_IDX_COEF_CUBIC:   rdMux = coefCubic_q;
      `CLC_IDX_COEF_SQUARE:  rdMux = coefSquare_q;
      `CLC_IDX_COEF_LINEAR:  rdMux = coefLinear_q;
      `CLC_IDX_COEF_OFFSET:  rdMux = coefOffset_q;
      `CLC_IDX_TEMP_FLOOR:   rdMux = tempFloor_q;
      `CLC_IDX_TEMP_CLAMP:   rdMux = tempClamp_q;
      `CLC_IDX_CTRL:         rdMux = {8'h00, ctrl_q};
      `CLC_IDX_STATUS:       rdMux = {11'h000, nvLate_q, nvWriteReq,
                                      run_q, disch_q, qual_q};
      `CLC_IDX_REMAINING:    rdMux = rm_q;
      `CLC_IDX_LEARNED:      rdMux = capUnits;
      `CLC_IDX_TEMPERATURE:  rdMux = temp_q;
      default:               rdMux = 16'h0000;
    endcase
  end

  // address phase capture, write retire, read wait state
  always @(posedge clk) begin
    if (!reset_n) begin
      idx_q      <= 8'h00;
      wrPend_q   <= 1'b0;
      mapped_q   <= 1'b0;
      rdPhase_q  <= 1'b0;
      hrdata     <= 32'h0000_0000;
      gaugeCfg_q <= 8'h00;
      miscCfg_q  <= 8'h00;
      lowBatt_q  <= `CLC_RST_LOW_BATT;
      ctrl_q     <= 8'h00;
      nearFull_q <= `CLC_RST_NEAR_FULL;
      designCap_q  <= `CLC_RST_DESIGN_CAP;
      learnLowT_q  <= `CLC_RST_LEARN_LOW_T;
      coefCubic_q  <= `CLC_RST_COEF_CUBIC;
      coefSquare_q <= `CLC_RST_COEF_SQUARE;
      coefLinear_q <= `CLC_RST_COEF_LINEAR;
      coefOffset_q <= `CLC_RST_COEF_OFFSET;
      tempFloor_q  <= `CLC_RST_TEMP_FLOOR;
      tempClamp_q  <= `CLC_RST_TEMP_CLAMP;
    end else begin
      wrPend_q <= busTake & hwrite;
      if (busTake) begin
        idx_q    <= busIdx;
        mapped_q <= busInMap & isMapped(busIdx);
      end
      if (busTake & ~hwrite)
        rdPhase_q <= 1'b1;
      else if (rdPhase_q) begin
        rdPhase_q <= 1'b0;
        hrdata    <= mapped_q ? {16'h0000, rdMux} : 32'h0000_0000;
      end
      // writes to status, readouts and unmapped words are dropped
      if (wrPend_q & mapped_q) begin
        case (idx_q)
          `CLC_IDX_GAUGE_CFG:   gaugeCfg_q   <= hwdata[7:0];
          `CLC_IDX_MISC_CFG:    miscCfg_q    <= hwdata[7:0];
          `CLC_IDX_LOW_BATT:    lowBatt_q    <= hwdata[7:0];
          `CLC_IDX_CTRL:        ctrl_q       <= hwdata[7:0];
          `CLC_IDX_NEAR_FULL:   nearFull_q   <= hwdata[15:0];
          `CLC_IDX_DESIGN_CAP:  designCap_q  <= hwdata[15:0];
          `CLC_IDX_LEARN_LOW_T: learnLowT_q  <= hwdata[15:0];
          `CLC_IDX_COEF_CUBIC:  coefCubic_q  <= hwdata[15:0];
          `CLC_IDX_COEF_SQUARE: coefSquare_q <= hwdata[15:0];
          `CLC_IDX_COEF_LINEAR: coefLinear_q <= hwdata[15:0];
          `CLC_IDX_COEF_OFFSET: coefOffset_q <= hwdata[15:0];
          `CLC_IDX_TEMP_FLOOR:  tempFloor_q  <= hwdata[15:0];
          `CLC_IDX_TEMP_CLAMP:  tempClamp_q  <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // temperature: one multiplier shared over three nested stages
  reg  signed [48:0] tProd;
  reg  signed [31:0] tNext;
  reg         [15:0] tCoef;
  always @* begin
    case (tStep_q)
      2'd0:    tCoef = coefSquare_q;
      2'd1:    tCoef = coefLinear_q;
      default: tCoef = coefOffset_q;
    endcase
    tProd = tAcc_q * $signed({1'b0, ad_q});
    tNext = tProd[47:16] + {{16{tCoef[15]}}, tCoef}; // RL1
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      tState_q <= T_IDLE;
      tStep_q  <= 2'd0;
      ad_q     <= 16'h0000;
      tAcc_q   <= 32'sd0;
      temp_q   <= 16'h0000;
    end else begin
      case (tState_q)
        T_IDLE: begin
          if (tempRawValid) begin
            if (tempRaw < tempFloor_q)
              temp_q <= tempClamp_q; // RL1
            else begin
              ad_q     <= tempRaw;
              tAcc_q   <= {{16{coefCubic_q[15]}}, coefCubic_q};
              tStep_q  <= 2'd0;
              tState_q <= T_STEP;
            end
          end
        end
        T_STEP: begin
          tAcc_q  <= tNext;
          tStep_q <= tStep_q + 2'd1;
          if (tStep_q == 2'd2) begin
            temp_q   <= tNext[15:0];
            tState_q <= T_IDLE;
          end
        end
        default: tState_q <= T_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // remaining charge: flows applied in order, then bounded
  reg [15:0] rmD;
  always @* begin
    rmD = rm_q;
    if (chargeValid)
      rmD = satAdd(rmD, toUnits(chargeMah, packVoltageMv, unitEnergy));
    if (dischargeValid)
      rmD = satSub(rmD, toUnits(dischargeMah, packVoltageMv, unitEnergy));
    if (selfDischargeValid)
      rmD = satSub(rmD, toUnits(selfDischargeMah, packVoltageMv,
                                unitEnergy)); // RL3
    if (loadEstValid)
      rmD = satSub(rmD, toUnits(loadEstMah, packVoltageMv, unitEnergy));
    if (recalValid)
      rmD = recalValue; // RL4
    if (rmD > capUnits)
      rmD = capUnits; // RL2
  end

  // ------------------------------------------------------------------
  // learning: tally, qualification and capacity update
  wire [23:0] lowProd  = fcc_q * lowBatt_q;
  wire [15:0] lowLevel = lowProd[23:8]; // RL12
  wire [20:0] cur32    = {currentMa, 5'b00000};
  wire [17:0] cap3     = {2'b00, designCap_q} + {1'b0, designCap_q, 1'b0};
  wire        lowCurr  = cur32 < {3'b000, cap3}; // RL19
  wire [15:0] vFloor   = satSub(levelTwoThresholdMv, `CLC_V_MARGIN_MV);
  wire [15:0] fillGap  = satSub(fcc_q, rm_q);
  wire [15:0] tallyOfs = gaugeCfg_q[`CLC_GCFG_TALLY_OFS] ?
                         {7'h00, fcc_q[15:7]} : 16'h0000; // RL9
  wire [15:0] floorCap = satSub(fcc_q, `CLC_MAX_DROP_MAH);
  wire [15:0] ceilCap  = satAdd(fcc_q, `CLC_MAX_RISE_MAH);

  reg [15:0] tallyD, chgAccD, estAccD, fccD, newCap;
  reg        qualD, dischD, runD, lowSeenD, learnD;
  always @* begin
    tallyD   = tally_q;
    chgAccD  = chgAcc_q;
    estAccD  = estAcc_q;
    qualD    = qual_q;
    dischD   = disch_q;
    runD     = run_q;
    lowSeenD = lowSeen_q;
    learnD   = 1'b0;
    newCap   = satAdd(tally_q, lowLevel); // RL11
    fccD     = fcc_q;
    // tally counts on its own, whatever remaining charge does
    if (run_q) begin
      if (dischargeValid)
        tallyD = satAdd(tallyD, dischargeMah); // RL7
      if (selfDischargeValid)
        tallyD = satAdd(tallyD, selfDischargeMah); // RL7
      if (loadEstValid)
        tallyD = satAdd(tallyD, loadEstMah); // RL7
    end
    if (disch_q) begin
      if (selfDischargeValid)
        estAccD = satAdd(estAccD, selfDischargeMah);
      if (loadEstValid)
        estAccD = satAdd(estAccD, loadEstMah);
      if (estAccD > `CLC_EST_LIMIT_MAH)
        qualD = 1'b0; // RL15
      if (chargeValid)
        chgAccD = satAdd(chgAccD, chargeMah);
      if (chgAccD >= `CLC_VALID_CHARGE_MAH) begin
        qualD  = 1'b0; // RL14
        dischD = 1'b0;
        runD   = 1'b0;
      end
      if (midrangeCorrect)
        qualD = 1'b0; // RL18
      if (!lowSeen_q && rm_q <= lowLevel) begin
        lowSeenD = 1'b1;
        if (lowCurr || overload)
          qualD = 1'b0; // RL19 RL20
      end
      if (levelTwoDetect && run_q) begin
        runD = 1'b0; // RL10
        if (temp_q < learnLowT_q || packVoltageMv < vFloor ||
            lowCurr || overload || unitEnergy)
          qualD = 1'b0; // RL16 RL17 RL19 RL20
        if (qualD) begin
          learnD = 1'b1; // RL23
          if (newCap < floorCap)
            fccD = floorCap; // RL22
          else if (newCap > ceilCap)
            fccD = ceilCap; // RL22
          else
            fccD = newCap;
        end
      end
    end else if (dischargeValid) begin
      // a fresh discharge restarts all bookkeeping
      dischD   = 1'b1;
      runD     = 1'b1;
      chgAccD  = 16'h0000;
      estAccD  = 16'h0000;
      lowSeenD = 1'b0;
      qualD    = (fillGap <= nearFull_q) & ~unitEnergy; // RL13 RL21
      if (fillGap <= nearFull_q)
        tallyD = satAdd(satSub(fillGap, tallyOfs), dischargeMah); // RL8
      else
        tallyD = 16'h0000;
    end
  end

  // gauge state registers; the stored value is caught after release
  always @(posedge clk) begin
    if (!reset_n) begin
      rm_q       <= 16'h0000;
      fcc_q      <= 16'h0000;
      tally_q    <= 16'h0000;
      chgAcc_q   <= 16'h0000;
      estAcc_q   <= 16'h0000;
      qual_q     <= 1'b0;
      disch_q    <= 1'b0;
      run_q      <= 1'b0;
      lowSeen_q  <= 1'b0;
      initLoad_q <= 1'b1;
    end else begin
      initLoad_q <= 1'b0;
      rm_q       <= rmD; // RL2
      tally_q    <= tallyD;
      chgAcc_q   <= chgAccD;
      estAcc_q   <= estAccD;
      qual_q     <= qualD; // RL21
      disch_q    <= dischD;
      run_q      <= runD;
      lowSeen_q  <= lowSeenD;
      if (initLoad_q)
        fcc_q <= nvStoredCapacity; // RL5
      else
        fcc_q <= fccD;
    end
  end

  // ------------------------------------------------------------------
  // write-back: request raised the cycle after an update, held to ack
  always @(posedge clk) begin
    if (!reset_n) begin
      nvWriteReq  <= 1'b0;
      nvWriteData <= 16'h0000;
      nvAge_q     <= 32'h0000_0000;
      nvLate_q    <= 1'b0;
    end else begin
      if (learnD) begin
        nvWriteReq  <= 1'b1; // RL6
        nvWriteData <= fccD; // RL6
        nvAge_q     <= 32'h0000_0000;
        nvLate_q    <= 1'b0;
      end else if (nvWriteReq) begin
        if (nvWriteAck)
          nvWriteReq <= 1'b0;
        nvAge_q <= nvAge_q + 32'h0000_0001;
        // a slow store is flagged, the request stays up
        if (nvAge_q >= WRITEBACK_LIMIT)
          nvLate_q <= 1'b1;
      end
    end
  end

endmodule // clc_capacity_learning_counter

`default_nettype wire

// ===== clc_capacity_defs.vh
`ifndef CLC_CAPACITY_DEFS_VH
`define CLC_CAPACITY_DEFS_VH

// register indices, byte address is four times the index
`define CLC_IDX_GAUGE_CFG     8'h29
`define CLC_IDX_MISC_CFG      8'h2A
`define CLC_IDX_LOW_BATT      8'h2E
`define CLC_IDX_NEAR_FULL     8'h2F
`define CLC_IDX_DESIGN_CAP    8'h31
`define CLC_IDX_STORED_CAP    8'h35
`define CLC_IDX_LEARN_LOW_T   8'h9B
`define CLC_IDX_COEF_CUBIC    8'hA4
`define CLC_IDX_COEF_SQUARE   8'hA6
`define CLC_IDX_COEF_LINEAR   8'hA8
`define CLC_IDX_COEF_OFFSET   8'hAA
`define CLC_IDX_TEMP_FLOOR    8'hAC
`define CLC_IDX_TEMP_CLAMP    8'hAE
`define CLC_IDX_CTRL          8'hC0
`define CLC_IDX_STATUS        8'hC1
`define CLC_IDX_REMAINING     8'hC2
`define CLC_IDX_LEARNED       8'hC3
`define CLC_IDX_TEMPERATURE   8'hC4

// field positions
`define CLC_MISC_INT_SENSOR   7
`define CLC_GCFG_TALLY_OFS    5
`define CLC_CTRL_UNIT_ENERGY  0
`define CLC_ST_QUALIFIED      0
`define CLC_ST_DISCHARGING    1
`define CLC_ST_TALLY_RUN      2
`define CLC_ST_NV_PENDING     3
`define CLC_ST_NV_LATE        4

// reset values
`define CLC_RST_COEF_CUBIC    16'h9183
`define CLC_RST_COEF_SQUARE   16'h5170
`define CLC_RST_COEF_LINEAR   16'hE28F
`define CLC_RST_COEF_OFFSET   16'h0FAC
`define CLC_RST_TEMP_FLOOR    16'h0000
`define CLC_RST_TEMP_CLAMP    16'h0FAC
`define CLC_RST_NEAR_FULL     16'h0064
`define CLC_RST_LOW_BATT      8'h0A
`define CLC_RST_DESIGN_CAP    16'h0FA0
`define CLC_RST_LEARN_LOW_T   16'h0000

// limits and timing
`define CLC_VALID_CHARGE_MAH  16'h000A
`define CLC_EST_LIMIT_MAH     16'h0100
`define CLC_V_MARGIN_MV       16'h0180
`define CLC_MAX_DROP_MAH      16'h0100
`define CLC_MAX_RISE_MAH      16'h0200
`define CLC_MWH_DIVISOR       32'd10000
`define CLC_WRITEBACK_MS      4000
`define CLC_CLK_KHZ           100000
`define CLC_WRITEBACK_CYCLES  (`CLC_WRITEBACK_MS * `CLC_CLK_KHZ)

`endif

// ===== clc_capacity_checker.sv
`timescale 1ns/100ps
`default_nettype none
module clc_capacity_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // events
  input wire logic        chargeValid,
  input wire logic [15:0] chargeMah,
  input wire logic        dischargeValid,
  input wire logic        midrangeCorrect,
  input wire logic        levelTwoDetect,
  input wire logic        overload,
  // store and flag
  input wire logic        nvWriteReq,
  input wire logic [15:0] nvWriteData,
  input wire logic        nvWriteAck,
  input wire logic        dischargeQualified
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // request taken by the slave
  logic take;
  assign take = hsel && hready && htrans[1];

  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rdwait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rdwait: assert property (p_rdwait) else $error("read wait wrong");
  property p_wrnow; take && hwrite |=> hreadyout; endproperty
  a_wrnow: assert property (p_wrnow) else $error("write stalled");
  // store request must not move while unanswered
  property p_nvhold;
    nvWriteReq && !nvWriteAck |=> nvWriteReq && $stable(nvWriteData);
  endproperty
  a_nvhold: assert property (p_nvhold) else $error("nv req lost");
  property p_nvdrop; nvWriteReq && nvWriteAck |=> !nvWriteReq; endproperty
  a_nvdrop: assert property (p_nvdrop) else $error("nv req stuck");
  property p_charge;
    chargeValid && chargeMah >= 16'h000A && !dischargeValid
      |=> !dischargeQualified;
  endproperty
  a_charge: assert property (p_charge) else $error("charge kept flag");
  property p_mid; midrangeCorrect && !dischargeValid |=> !dischargeQualified;
  endproperty
  a_mid: assert property (p_mid) else $error("midrange kept flag");
  property p_over; levelTwoDetect && overload |=> !dischargeQualified;
  endproperty
  a_over: assert property (p_over) else $error("overload kept flag");
  property p_learn;
    $rose(nvWriteReq) |-> $past(levelTwoDetect) && $past(dischargeQualified);
  endproperty
  a_learn: assert property (p_learn) else $error("update unqualified");
  property p_start; $rose(dischargeQualified) |-> $past(dischargeValid);
  endproperty
  a_start: assert property (p_start) else $error("flag without discharge");
endmodule // clc_capacity_checker
`default_nettype wire

// ===== clc_nv_store_model.sv
`timescale 1ns/100ps
`default_nettype none
module clc_nv_store_model #(
  parameter logic [15:0] STORED = 16'h03E8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // store port
  input  wire logic        nvWriteReq,
  input  wire logic [15:0] nvWriteData,
  output var  logic        nvWriteAck,
  output var  logic [15:0] nvStoredCapacity
);
  logic [1:0] cnt_q = 2'h0;
  logic       slow_q = 1'b0;
  initial nvWriteAck = 1'b0;
  initial nvStoredCapacity = STORED;
  // alternates prompt and slow answers; contents survive reset
  always @(posedge clk) begin
    if (!reset_n || nvWriteAck) begin
      nvWriteAck <= 1'b0;
      cnt_q <= 2'h0;
      slow_q <= slow_q ^ nvWriteAck;
    end else if (nvWriteReq) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == {slow_q, 1'b1}) begin
        nvWriteAck <= 1'b1;
        nvStoredCapacity <= nvWriteData;
      end
    end
  end
endmodule // clc_nv_store_model
`default_nettype wire

// ===== tb_clc_capacity_learning_counter.sv
`timescale 1ns/100ps
`default_nettype none
module tb_clc_capacity_learning_counter;
  logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        chargeValid = 1'b0, dischargeValid = 1'b0, overload = 1'b0;
  logic        tempRawValid = 1'b0, levelTwoDetect = 1'b0, recalValid = 1'b0;
  logic        midrangeCorrect = 1'b0, dphRead = 1'b0;
  logic        selfDischargeValid = 1'b0, loadEstValid = 1'b0;
  logic [15:0] selfDischargeMah = 16'h0, loadEstMah = 16'h0;
  logic [15:0] chargeMah = 16'h0, dischargeMah = 16'h0, tempRaw = 16'h0;
  logic [15:0] recalValue = 16'h0, a, t;
  logic [15:0] packVoltageMv = 16'h0BB8, levelTwoThresholdMv = 16'h0BB8;
  logic [15:0] currentMa = 16'h03E8;
  wire  logic [31:0] hrdata;
  wire  logic        hreadyout, hresp, nvWriteReq, nvWriteAck;
  wire  logic        internalSensorSelect, dischargeQualified;
  wire  logic [15:0] nvWriteData, nvStoredCapacity;
  logic [31:0] expQ[$], nvQ[$];
  int failures = 0, comparisons = 0, seed = 67, k;
  logic [7:0]  ri[10] = '{8'hA4, 8'hA6, 8'hA8, 8'hAA, 8'hAC, 8'hAE, 8'h35,
                          8'hC3, 8'h50, 8'hC2};
  logic [15:0] rv[10] = '{16'h9183, 16'h5170, 16'hE28F, 16'h0FAC, 16'h0000,
                          16'h0FAC, 16'h03E8, 16'h03E8, 16'h0000, 16'h0000};

  clc_capacity_learning_counter #(.WRITEBACK_LIMIT(50)) clc_capacity_learning_counter_i (
    .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chargeValid,
    .chargeMah, .dischargeValid, .dischargeMah, .selfDischargeValid,
    .selfDischargeMah, .loadEstValid,
    .loadEstMah, .packVoltageMv, .currentMa, .overload,
    .tempRawValid, .tempRaw, .levelTwoDetect, .levelTwoThresholdMv,
    .recalValid, .recalValue, .midrangeCorrect, .nvStoredCapacity,
    .nvWriteReq, .nvWriteData, .nvWriteAck, .internalSensorSelect,
    .dischargeQualified);
  clc_nv_store_model clc_nv_store_model_i (.clk, .reset_n, .nvWriteReq,
    .nvWriteData, .nvWriteAck, .nvStoredCapacity);

  always #5 clk = ~clk;

  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one single transfer; waits are bounded
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin failures++; test_done(); end
  endtask
  task rd(input logic [7:0] idx, input logic [15:0] e);
    expQ.push_back({16'h0, e});
    bus(1'b0, idx, 32'h0);
  endtask
  // one-cycle event pulse, then time to settle and compute
  task ev(input int kind, input logic [15:0] v);
    case (kind)
      0: begin chargeMah <= v; chargeValid <= 1'b1; end
      1: begin dischargeMah <= v; dischargeValid <= 1'b1; end
      2: begin tempRaw <= v; tempRawValid <= 1'b1; end
      3: begin recalValue <= v; recalValid <= 1'b1; end
      4: levelTwoDetect <= 1'b1;
      5: midrangeCorrect <= 1'b1;
      6: begin selfDischargeMah <= v; selfDischargeValid <= 1'b1; end
      default: begin loadEstMah <= v; loadEstValid <= 1'b1; end
    endcase
    @(posedge clk);
    {chargeValid, dischargeValid, tempRawValid} <= 3'h0;
    {recalValid, levelTwoDetect, midrangeCorrect} <= 3'h0;
    {selfDischargeValid, loadEstValid} <= 2'h0;
    repeat (6) @(posedge clk);
  endtask

  // watcher: every finished read and store write takes the oldest note
  always @(posedge clk) begin
    if (dphRead && hreadyout === 1'b1) begin
      if (expQ.size() == 0) check("read queue", 32'h1, 32'h0);
      else check("hrdata", hrdata, expQ.pop_front());
    end
    if (nvWriteReq === 1'b1 && nvWriteAck === 1'b1) begin
      if (nvQ.size() == 0) check("nv queue", 32'h1, 32'h0);
      else check("nvWriteData", {16'h0, nvWriteData}, nvQ.pop_front());
    end
    if (hreadyout === 1'b1) dphRead <= hsel && htrans[1] && !hwrite;
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 10; k++) rd(ri[k], rv[k]);
    bus(1'b1, 8'h2A, 32'h80);
    rd(8'h2A, 16'h0080);
    check("sensor", {31'h0, internalSensorSelect}, 32'h1);
    $display("test reset values done");
    // linear term only: result is raw/4 plus offset, floor gives clamp
    bus(1'b1, 8'hA4, 32'h0);
    bus(1'b1, 8'hA6, 32'h0);
    bus(1'b1, 8'hA8, 32'h4000);
    a = 16'h0100 + ($random(seed) & 16'h00FF);
    t = ($random(seed) & 16'h3FFC) | 16'h0100;
    bus(1'b1, 8'hAA, {16'h0, a});
    bus(1'b1, 8'hAC, 32'h40);
    bus(1'b1, 8'hAE, 32'h0BAD);
    ev(2, t);
    rd(8'hC4, t / 16'h4 + a);
    ev(2, 16'h0020);
    rd(8'hC4, 16'h0BAD);
    $display("test temperature done");
    // 900 of 1000 is the near-full edge; preset 100-7, plus 500, plus 39
    bus(1'b1, 8'h29, 32'h20);
    ev(0, 16'h0384);
    ev(1, 16'h01F4);
    rd(8'hC2, 16'h0190);
    check("qualified", {31'h0, dischargeQualified}, 32'h1);
    nvQ.push_back(32'h02E8);
    ev(4, 16'h0);
    rd(8'hC3, 16'h02E8);
    rd(8'h35, 16'h02E8);
    check("nv drained", nvQ.size(), 32'h0);
    $display("test learning done");
    // overload at level two, then a midrange correction, then a self-discharge estimate over 256 mAh
    for (k = 0; k < 3; k++) begin
      ev(0, 16'h07D0);
      rd(8'hC2, 16'h02E8);
      ev(1, 16'h000A);
      check("qualified", {31'h0, dischargeQualified}, 32'h1);
      if (k > 0) ev(k + 4, 16'h0101);
      overload <= (k == 0);
      ev(4, 16'h0);
      overload <= 1'b0;
      check("disqualified", {31'h0, dischargeQualified}, 32'h0);
      check("no update", {31'h0, nvWriteReq}, 32'h0);
    end
    rd(8'hC3, 16'h02E8);
    // requalify from full, load estimate in tally
    ev(0, 16'h07D0);
    ev(1, 16'h01F4);
    ev(7, 16'h0040);
    nvQ.push_back(32'h0251);
    ev(4, 16'h0);
    rd(8'hC3, 16'h0251);
    $display("test disqualify done");
    ev(3, 16'h0141);
    rd(8'hC2, 16'h0141);
    ev(1, 16'h0FFF);
    rd(8'hC2, 16'h0000);
    bus(1'b1, 8'hC0, 32'h1);
    rd(8'hC3, 16'h00B1);
    $display("test recalibrate done");
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule // tb_clc_capacity_learning_counter

bind clc_capacity_learning_counter clc_capacity_checker clc_capacity_checker_i (
  .clk, .reset_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .chargeValid, .chargeMah, .dischargeValid, .midrangeCorrect,
  .levelTwoDetect, .overload, .nvWriteReq, .nvWriteData, .nvWriteAck,
  .dischargeQualified);
`default_nettype wire
